// File: src/fwg_pkg.sv
/*
 * Constants, types and timing figures of the flash write guard.
 * Assumes a 20 MHz core clock and a 2 MB array on 24-bit addresses.
 */
// ==========================================================
// Functional notes
// - Suspend is entered within 30 us of an accepted suspend.
// - Page program of up to 256 bytes takes 2 ms, 3 ms at most.
// - Every erase kind takes 8 ms, 20 ms at most.
// - Delivered state: array erased to FFh, status bits all zero.
// - Power-up puts the command machine into standby by itself.
// - Data-changing commands are accepted only on whole bytes.
// - Data-changing commands need the write enable latch set.
// - Protect bits select a readable but unchangeable region.
// - Write-protect pin low freezes protect and status-protect bits.
// - Deep power-down ignores all but the release command.
// - Plain mode: side bit picks end, size 64 KB up to 1 MB.
// - Fine mode: 4 KB to 32 KB at the chosen end of the array.
// - Complement bit inverts the protected region exactly.
// - Program or erase touching protected memory is ignored.
// - Chip select must rise on a byte boundary or command fails.
// - Input bits are sampled on the rising serial clock edge.
package fwg_pkg;

   // ==========================================================
   // Timing
   localparam int CLK_PERIOD_NS = 50;
   localparam int SUSPEND_LAT_US = 30;
   localparam int SUSPEND_LAT_CYC = SUSPEND_LAT_US * 1000 / CLK_PERIOD_NS;
   localparam int RESUME_GAP_NS = 300;
   localparam int RESUME_GAP_CYC =
      (RESUME_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PAGE_PROGRAM_MS = 2;
   localparam int PAGE_PROGRAM_CYC =
      PAGE_PROGRAM_MS * 1000000 / CLK_PERIOD_NS;
   localparam int ERASE_MS = 8;
   localparam int ERASE_CYC = ERASE_MS * 1000000 / CLK_PERIOD_NS;
   localparam int POWERUP_SELECT_US = 70;
   localparam int POWERUP_CYC =
      (POWERUP_SELECT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ==========================================================
   // Array geometry, as address span bits
   localparam int ARRAY_AW = 21;
   localparam int SPAN_PAGE = 8;
   localparam int SPAN_SECTOR = 12;
   localparam int SPAN_BLOCK32 = 15;
   localparam int SPAN_BLOCK64 = 16;
   localparam logic [7:0] ERASED_BYTE = 8'hFF;
   localparam logic [7:0] STATUS_RESET = 8'h00;

   // ==========================================================
   // Status write byte fields
   localparam int SR1_BP_LSB = 2;
   localparam int SR1_SP0 = 7;
   localparam int SR2_SP1 = 0;
   localparam int SR2_COMPL = 6;

   // ==========================================================
   // Synchroniser lanes and their idle values
   localparam int IDX_CS = 0;
   localparam int IDX_TGL = 1;
   localparam int IDX_AL = 2;
   localparam int IDX_WP = 3;
   localparam logic [3:0] SYNC_RESET = 4'h9;

   // ==========================================================
   // Command codes
   localparam logic [7:0] OPC_SET_WRITE_LATCH = 8'h06;
   localparam logic [7:0] OPC_CLR_WRITE_LATCH = 8'h04;
   localparam logic [7:0] OPC_WRITE_STATUS = 8'h01;
   localparam logic [7:0] OPC_PAGE_PROGRAM = 8'h02;
   localparam logic [7:0] OPC_PAGE_ERASE = 8'h81;
   localparam logic [7:0] OPC_SECTOR_ERASE = 8'h20;
   localparam logic [7:0] OPC_BLOCK32_ERASE = 8'h52;
   localparam logic [7:0] OPC_BLOCK64_ERASE = 8'hD8;
   localparam logic [7:0] OPC_CHIP_ERASE = 8'h60;
   localparam logic [7:0] OPC_DEEP_PD = 8'hB9;
   localparam logic [7:0] OPC_RELEASE_PD = 8'hAB;
   localparam logic [7:0] OPC_SUSPEND = 8'h75;
   localparam logic [7:0] OPC_RESUME = 8'h7A;

   typedef enum logic [2:0] {
      FWG_ST_POWERUP, FWG_ST_STANDBY, FWG_ST_BUSY,
      FWG_ST_SUSPENDING, FWG_ST_SUSPENDED, FWG_ST_DEEP_PD
   } fwg_state_t;

   typedef enum logic [2:0] {
      FWG_OP_PROGRAM, FWG_OP_PAGE_ERASE, FWG_OP_SECTOR_ERASE,
      FWG_OP_BLOCK32_ERASE, FWG_OP_BLOCK64_ERASE, FWG_OP_CHIP_ERASE
   } fwg_op_t;

endpackage

// File: src/fwg_link_if.sv
/*
 * Byte link from the serial clock receiver to the core.
 * Assumes the receiver writes and the core samples the toggle and aligned flag through synchronisers.
 */
`timescale 1ns/1ps
interface fwg_link_if;
   logic [7:0] byte_data;
   logic byte_tgl;
   logic aligned;
   modport rx (output byte_data, output byte_tgl, output aligned);
   modport core (input byte_data, input byte_tgl, input aligned);
endinterface

// File: src/fwg_spi_rx.sv
/*
 * Serial clock domain receiver: shifts in bytes, flags byte completion.
 * Assumes the serial clock runs only while chip select is low.
 */
`timescale 1ns/1ps
module fwg_spi_rx (
   input wire logic reset,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic si,
   fwg_link_if.rx link
);
   typedef struct packed {
      logic [7:0] shift;
      logic [7:0] data;
      logic tgl;
      logic aligned;
   } fwg_rx_t;

   fwg_rx_t r_reg;
   fwg_rx_t r_next;
   logic [2:0] bit_cnt_reg;

   // ==========================================================
   // Shifter
   always_comb begin
      r_next = r_reg;
      r_next.shift = {r_reg.shift[6:0], si};
      r_next.aligned = (bit_cnt_reg == 3'h7);
      if (bit_cnt_reg == 3'h7) begin
         r_next.data = {r_reg.shift[6:0], si};
         r_next.tgl = ~r_reg.tgl;
      end
   end

   always_ff @(posedge sclk or posedge reset) begin
      if (reset) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   // Bit position restarts with every frame and after reset.
   always_ff @(posedge sclk or posedge cs_n or posedge reset) begin
      if (cs_n || reset) begin
         bit_cnt_reg <= 3'h0;
      end else begin
         bit_cnt_reg <= bit_cnt_reg + 3'h1;
      end
   end

   assign link.byte_data = r_reg.data;
   assign link.byte_tgl = r_reg.tgl;
   assign link.aligned = r_reg.aligned;

   // ==========================================================
   // Checks
   a_byte_toggle: assert property (@(posedge sclk) disable iff (reset)
      (bit_cnt_reg == 3'h7 && !cs_n) |=> $changed(r_reg.tgl))
      else $error("byte completion did not toggle the link");
   a_partial_flag: assert property (@(posedge sclk) disable iff (reset)
      (bit_cnt_reg != 3'h7) |=> !r_reg.aligned)
      else $error("partial byte left the aligned flag set");

endmodule

// File: src/fwg_flash_write_guard.sv
/*
 * Write guard core: command decode, protection, program/erase timing.
 * Assumes a serial host on sclk/cs_n/si and a 20 MHz clk beside it.
 */
`timescale 1ns/1ps
module fwg_flash_write_guard #(
   parameter int PROG_CYC = fwg_pkg::PAGE_PROGRAM_CYC,
   parameter int ERASE_CYC = fwg_pkg::ERASE_CYC,
   parameter int CNT_W = 18
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic si,
   input wire logic wp_n,
   output logic busy,
   output logic write_enable_latch,
   output logic suspended,
   output logic deep_power_down,
   output logic protect_granularity_bit,
   output logic protect_side_bit,
   output logic protect_size_bit2,
   output logic protect_size_bit1,
   output logic protect_size_bit0,
   output logic protect_complement,
   output logic [1:0] status_protect_bits,
   output logic op_start,
   output logic [2:0] op_kind,
   output logic [20:0] op_addr,
   output logic op_done,
   output logic cmd_reject
);
   localparam logic [CNT_W-1:0] PROG_N = CNT_W'(PROG_CYC);
   localparam logic [CNT_W-1:0] ERASE_N = CNT_W'(ERASE_CYC);

   typedef struct packed {
      fwg_pkg::fwg_state_t st;
      logic [3:0] s1;
      logic [3:0] s2;
      logic [3:0] s3;
      logic [3:0] v;
      logic [1:0] end_dly;
      logic [2:0] nbytes;
      logic [7:0] opcode;
      logic [23:0] addr;
      logic [7:0] sr1;
      logic [7:0] sr2;
      logic [4:0] bp;
      logic compl;
      logic [1:0] srp;
      logic latch;
      logic [CNT_W-1:0] cnt;
      logic [9:0] sus_cnt;
      logic [3:0] gap_cnt;
      logic [10:0] pwr_cnt;
      logic [2:0] kind;
      logic [20:0] oaddr;
      logic start;
      logic done;
      logic reject;
   } fwg_core_t;

   fwg_core_t r_reg;
   fwg_core_t r_next;
   fwg_link_if link ();

   fwg_spi_rx u_rx (
      .reset(reset),
      .sclk(sclk),
      .cs_n(cs_n),
      .si(si),
      .link(link.rx)
   );

   // ==========================================================
   // Protection decode
   function automatic logic prot_hit(input logic [4:0] bp,
         input logic compl, input logic [21:0] lo, input logic [21:0] hi);
      logic none;
      logic all;
      logic low_part;
      int k;
      logic [21:0] size;
      logic [21:0] bound;
      logic hit;
      none = (bp[2:0] == 3'h0);
      all = (bp[2:1] == 2'h3);
      if (!bp[4]) begin
         k = 15 + int'(bp[2:0]);
      end else begin
         k = bp[2] ? 15 : 11 + int'(bp[1:0]);
      end
      size = 22'h1 << k;
      bound = bp[3] ? size : 22'h200000 - size;
      low_part = bp[3] ^ compl;
      hit = low_part ? (lo < bound) : (hi >= bound);
      if (compl ? none : all) begin
         hit = 1'b1;
      end else if (compl ? all : none) begin
         hit = 1'b0;
      end
      return hit;
   endfunction

   // ==========================================================
   // Core logic
   always_comb begin
      logic tgl_evt;
      logic len_ok;
      logic mem_cmd;
      logic whole;
      int span;
      fwg_pkg::fwg_op_t kind;
      logic [21:0] t_lo;
      logic [21:0] t_hi;
      logic [21:0] mask;
      tgl_evt = 1'b0;
      len_ok = 1'b0;
      mem_cmd = 1'b0;
      whole = 1'b0;
      span = fwg_pkg::SPAN_PAGE;
      kind = fwg_pkg::FWG_OP_PROGRAM;
      t_lo = '0;
      t_hi = '0;
      mask = '0;
      r_next = r_reg;
      r_next.start = 1'b0;
      r_next.done = 1'b0;
      r_next.reject = 1'b0;

      r_next.s1 = {wp_n, link.aligned, link.byte_tgl, cs_n};
      r_next.s2 = r_reg.s1;
      r_next.s3 = r_reg.s2;
      for (int i = 0; i < 4; i++) begin
         if (r_reg.s2[i] == r_reg.s3[i]) begin
            r_next.v[i] = r_reg.s3[i];
         end
      end
      tgl_evt = r_next.v[fwg_pkg::IDX_TGL] != r_reg.v[fwg_pkg::IDX_TGL];
      r_next.end_dly = {r_reg.end_dly[0],
         r_next.v[fwg_pkg::IDX_CS] & ~r_reg.v[fwg_pkg::IDX_CS]};
      if (!r_next.v[fwg_pkg::IDX_CS] && r_reg.v[fwg_pkg::IDX_CS]) begin
         r_next.nbytes = 3'h0;
      end else if (tgl_evt) begin
         if (r_reg.nbytes == 3'h0) begin
            r_next.opcode = link.byte_data;
         end else if (r_reg.nbytes <= 3'h3) begin
            r_next.addr = {r_reg.addr[15:0], link.byte_data};
         end
         if (r_reg.nbytes == 3'h1) begin
            r_next.sr1 = link.byte_data;
         end
         if (r_reg.nbytes == 3'h2) begin
            r_next.sr2 = link.byte_data;
         end
         if (r_reg.nbytes != 3'h7) begin
            r_next.nbytes = r_reg.nbytes + 3'h1;
         end
      end

      if (r_reg.gap_cnt != 4'h0) begin
         r_next.gap_cnt = r_reg.gap_cnt - 4'h1;
      end

      // Timed work of the operation engine.
      unique case (r_reg.st)
         fwg_pkg::FWG_ST_POWERUP: begin
            r_next.pwr_cnt = r_reg.pwr_cnt + 11'h1;
            if (r_reg.pwr_cnt == 11'(fwg_pkg::POWERUP_CYC - 1)) begin
               r_next.st = fwg_pkg::FWG_ST_STANDBY;
            end
         end
         fwg_pkg::FWG_ST_BUSY, fwg_pkg::FWG_ST_SUSPENDING: begin
            if (r_reg.cnt == CNT_W'(1)) begin
               r_next.st = fwg_pkg::FWG_ST_STANDBY;
               r_next.latch = 1'b0;
               r_next.done = 1'b1;
            end else begin
               r_next.cnt = r_reg.cnt - CNT_W'(1);
               if (r_reg.st == fwg_pkg::FWG_ST_SUSPENDING) begin
                  r_next.sus_cnt = r_reg.sus_cnt - 10'h1;
                  if (r_reg.sus_cnt == 10'h1) begin
                     r_next.st = fwg_pkg::FWG_ST_SUSPENDED;
                  end
               end
            end
         end
         default: begin
         end
      endcase

      // Command at the end of a frame, once the flags have settled.
      len_ok = r_reg.v[fwg_pkg::IDX_AL] && r_reg.nbytes != 3'h0;
      if (r_reg.end_dly[1]) begin
         unique case (r_reg.opcode)
            fwg_pkg::OPC_PAGE_PROGRAM: begin
               mem_cmd = 1'b1;
            end
            fwg_pkg::OPC_PAGE_ERASE: begin
               mem_cmd = 1'b1;
               kind = fwg_pkg::FWG_OP_PAGE_ERASE;
            end
            fwg_pkg::OPC_SECTOR_ERASE: begin
               mem_cmd = 1'b1;
               span = fwg_pkg::SPAN_SECTOR;
               kind = fwg_pkg::FWG_OP_SECTOR_ERASE;
            end
            fwg_pkg::OPC_BLOCK32_ERASE: begin
               mem_cmd = 1'b1;
               span = fwg_pkg::SPAN_BLOCK32;
               kind = fwg_pkg::FWG_OP_BLOCK32_ERASE;
            end
            fwg_pkg::OPC_BLOCK64_ERASE: begin
               mem_cmd = 1'b1;
               span = fwg_pkg::SPAN_BLOCK64;
               kind = fwg_pkg::FWG_OP_BLOCK64_ERASE;
            end
            fwg_pkg::OPC_CHIP_ERASE: begin
               mem_cmd = 1'b1;
               whole = 1'b1;
               span = fwg_pkg::ARRAY_AW;
               kind = fwg_pkg::FWG_OP_CHIP_ERASE;
            end
            default: begin
            end
         endcase
         mask = (22'h1 << span) - 22'h1;
         t_lo = whole ? 22'h0 : {1'b0, r_reg.addr[20:0]} & ~mask;
         t_hi = t_lo | mask;

         unique case (r_reg.st)
            fwg_pkg::FWG_ST_DEEP_PD: begin
               if (r_reg.opcode == fwg_pkg::OPC_RELEASE_PD && len_ok) begin
                  r_next.st = fwg_pkg::FWG_ST_STANDBY;
               end
            end
            fwg_pkg::FWG_ST_BUSY: begin
               if (r_reg.opcode == fwg_pkg::OPC_SUSPEND && len_ok &&
                     r_reg.gap_cnt == 4'h0) begin
                  r_next.st = fwg_pkg::FWG_ST_SUSPENDING;
                  r_next.sus_cnt = 10'(fwg_pkg::SUSPEND_LAT_CYC);
               end
            end
            fwg_pkg::FWG_ST_SUSPENDED: begin
               if (r_reg.opcode == fwg_pkg::OPC_RESUME && len_ok) begin
                  r_next.st = fwg_pkg::FWG_ST_BUSY;
                  r_next.gap_cnt = 4'(fwg_pkg::RESUME_GAP_CYC);
               end
            end
            fwg_pkg::FWG_ST_STANDBY: begin
               if (r_reg.opcode == fwg_pkg::OPC_SET_WRITE_LATCH &&
                     len_ok && r_reg.nbytes == 3'h1) begin
                  r_next.latch = 1'b1;
               end
               if (r_reg.opcode == fwg_pkg::OPC_CLR_WRITE_LATCH &&
                     len_ok && r_reg.nbytes == 3'h1) begin
                  r_next.latch = 1'b0;
               end
               if (r_reg.opcode == fwg_pkg::OPC_DEEP_PD && len_ok &&
                     r_reg.nbytes == 3'h1) begin
                  r_next.st = fwg_pkg::FWG_ST_DEEP_PD;
               end
               if (r_reg.opcode == fwg_pkg::OPC_WRITE_STATUS) begin
                  if (len_ok && r_reg.nbytes >= 3'h2 && r_reg.latch &&
                        r_reg.v[fwg_pkg::IDX_WP]) begin
                     r_next.bp = r_reg.sr1[fwg_pkg::SR1_BP_LSB +: 5];
                     r_next.srp[0] = r_reg.sr1[fwg_pkg::SR1_SP0];
                     if (r_reg.nbytes >= 3'h3) begin
                        r_next.srp[1] = r_reg.sr2[fwg_pkg::SR2_SP1];
                        r_next.compl = r_reg.sr2[fwg_pkg::SR2_COMPL];
                     end
                     r_next.latch = 1'b0;
                  end else begin
                     r_next.reject = 1'b1;
                  end
               end
               if (mem_cmd) begin
                  if (len_ok && r_reg.latch &&
                        (whole ? r_reg.nbytes == 3'h1
                               : r_reg.nbytes >= 3'h4) &&
                        !prot_hit(r_reg.bp, r_reg.compl, t_lo, t_hi)) begin
                     r_next.st = fwg_pkg::FWG_ST_BUSY;
                     r_next.start = 1'b1;
                     r_next.kind = kind;
                     r_next.oaddr = t_lo[20:0];
                     r_next.gap_cnt = 4'h0;
                     r_next.cnt = (kind == fwg_pkg::FWG_OP_PROGRAM) ?
                        PROG_N : ERASE_N;
                  end else begin
                     r_next.reject = 1'b1;
                  end
               end
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         r_reg <= '0;
         r_reg.st <= fwg_pkg::FWG_ST_POWERUP;
         r_reg.s1 <= fwg_pkg::SYNC_RESET;
         r_reg.s2 <= fwg_pkg::SYNC_RESET;
         r_reg.s3 <= fwg_pkg::SYNC_RESET;
         r_reg.v <= fwg_pkg::SYNC_RESET;
      end else begin
         r_reg <= r_next;
      end
   end

   // ==========================================================
   // Outputs
   assign busy = r_reg.st inside {fwg_pkg::FWG_ST_BUSY,
      fwg_pkg::FWG_ST_SUSPENDING, fwg_pkg::FWG_ST_SUSPENDED};
   assign suspended = (r_reg.st == fwg_pkg::FWG_ST_SUSPENDED);
   assign deep_power_down = (r_reg.st == fwg_pkg::FWG_ST_DEEP_PD);
   assign write_enable_latch = r_reg.latch;
   assign protect_granularity_bit = r_reg.bp[4];
   assign protect_side_bit = r_reg.bp[3];
   assign protect_size_bit2 = r_reg.bp[2];
   assign protect_size_bit1 = r_reg.bp[1];
   assign protect_size_bit0 = r_reg.bp[0];
   assign protect_complement = r_reg.compl;
   assign status_protect_bits = r_reg.srp;
   assign op_start = r_reg.start;
   assign op_kind = r_reg.kind;
   assign op_addr = r_reg.oaddr;
   assign op_done = r_reg.done;
   assign cmd_reject = r_reg.reject;

   // ==========================================================
   // Checks
   localparam int A_SUS_MAX = fwg_pkg::SUSPEND_LAT_CYC;
   logic [CNT_W-1:0] age_reg;
   logic running;

   assign running = r_reg.st inside {fwg_pkg::FWG_ST_BUSY,
      fwg_pkg::FWG_ST_SUSPENDING};
   always_ff @(posedge clk) begin
      if (reset) begin
         age_reg <= '0;
      end else if (r_reg.start) begin
         age_reg <= CNT_W'(1);
      end else if (running) begin
         age_reg <= age_reg + CNT_W'(1);
      end
   end

   default clocking a_cb @(posedge clk);
   endclocking
   default disable iff (reset);

   sequence s_suspend_taken;
      $rose(r_reg.st == fwg_pkg::FWG_ST_SUSPENDING);
   endsequence
   sequence s_suspend_left;
      ##[1:A_SUS_MAX] (r_reg.st != fwg_pkg::FWG_ST_SUSPENDING);
   endsequence

   a_suspend_latency: assert property (s_suspend_taken |-> s_suspend_left)
      else $error("suspend not entered in time");
   a_program_time: assert property (op_done &&
      op_kind == fwg_pkg::FWG_OP_PROGRAM |-> age_reg == PROG_N)
      else $error("program duration wrong");
   a_erase_time: assert property (op_done &&
      op_kind != fwg_pkg::FWG_OP_PROGRAM |-> age_reg == ERASE_N)
      else $error("erase duration wrong");
   a_powerup_standby: assert property (
      r_reg.st == fwg_pkg::FWG_ST_POWERUP |=>
      r_reg.st inside {fwg_pkg::FWG_ST_POWERUP, fwg_pkg::FWG_ST_STANDBY})
      else $error("power-up left for a state other than standby");
   a_latch_needed: assert property ($rose(op_start) |->
      $past(r_reg.latch) && r_reg.latch && $past(r_reg.v[fwg_pkg::IDX_AL]))
      else $error("operation started without latch or alignment");
   a_protect_honoured: assert property (op_start |->
      !prot_hit(r_reg.bp, r_reg.compl, {1'b0, op_addr}, {1'b0, op_addr}))
      else $error("operation started inside protected region");
   a_chip_erase_guard: assert property (op_start &&
      op_kind == fwg_pkg::FWG_OP_CHIP_ERASE |-> (r_reg.compl ?
      r_reg.bp[2:1] == 2'h3 : r_reg.bp[2:0] == 3'h0))
      else $error("chip erase started with protection set");
   a_wp_freeze: assert property (!r_reg.v[fwg_pkg::IDX_WP] |=>
      $stable(r_reg.bp) && $stable(r_reg.srp))
      else $error("protect bits changed while write-protect low");
   a_deep_pd_lock: assert property (
      r_reg.st == fwg_pkg::FWG_ST_DEEP_PD |=> !op_start &&
      $stable(r_reg.latch) && $stable(r_reg.bp))
      else $error("command acted during deep power-down");
   a_busy_release: assert property (op_done |->
      !busy && !write_enable_latch && $past(busy))
      else $error("end of operation did not clear busy and latch");

endmodule

// File: testbench/fwg_spi_host.sv
/* Serial host model: sends one frame MSB first in clock mode 0.
   Assumes the bench spaces frames and keeps the power-up delay. */
`timescale 1ns/1ps
module fwg_spi_host (
   output logic sclk,
   output logic cs_n,
   output logic si
);
   // ==========================================================
   // Idle: deselected, clock stands low.
   initial begin
      sclk = 1'h0;
      cs_n = 1'h1;
      si = 1'h0;
   end
   // ==========================================================
   // Frame: data changes while low, taken on the rising edge.
   task automatic frame(input logic [39:0] d, input int n);
      cs_n = 1'h0;
      for (int i = 0; i < n; i++) begin
         si = d[39 - i];
         #40 sclk = 1'h1;
         #40 sclk = 1'h0;
      end
      #40 cs_n = 1'h1;
      si = ~si;
   endtask
endmodule

// File: testbench/tb_top.sv
/* Bench for the write guard: host frames, checks at the guard's pins.
   Assumes shortened program and erase counts. */
`timescale 1ns/1ps
module tb_top;
   localparam int PC = 50;
   localparam int EC = 800;
   localparam logic [40:0] PT [8] = '{
      {8'h04, 8'h00, 24'h1F0000, 1'h0}, {8'h04, 8'h00, 24'h1EF000, 1'h1},
      {8'hA4, 8'h01, 24'h00F000, 1'h0}, {8'h24, 8'h00, 24'h010000, 1'h1},
      {8'h44, 8'h00, 24'h1FF000, 1'h0}, {8'h44, 8'h00, 24'h1FE000, 1'h1},
      {8'h04, 8'h40, 24'h1F0000, 1'h1}, {8'h00, 8'h40, 24'h000000, 1'h0}};
   logic clk, reset, sclk, cs_n, si, wp_n, busy, latch, susp, dpd;
   localparam logic [7:0] EOPC [4] = '{8'h81, 8'h20, 8'h52, 8'hD8};
   logic compl, start, done, rej;
   logic [40:0] p;
   logic [4:0] pb;
   logic [1:0] spb;
   logic [2:0] kind;
   logic [20:0] addr;
   int miscompares = 0, checks = 0, n_start = 0, n_rej = 0, cyc = 0;
   fwg_spi_host i_fwg_spi_host (.sclk(sclk), .cs_n(cs_n), .si(si));
   fwg_flash_write_guard #(.PROG_CYC(PC), .ERASE_CYC(EC))
      i_fwg_flash_write_guard (.clk(clk), .reset(reset), .sclk(sclk),
      .cs_n(cs_n), .si(si), .wp_n(wp_n), .busy(busy),
      .write_enable_latch(latch), .suspended(susp), .deep_power_down(dpd),
      .protect_granularity_bit(pb[4]), .protect_side_bit(pb[3]),
      .protect_size_bit2(pb[2]), .protect_size_bit1(pb[1]),
      .protect_size_bit0(pb[0]), .protect_complement(compl),
      .status_protect_bits(spb), .op_start(start), .op_kind(kind),
      .op_addr(addr), .op_done(done), .cmd_reject(rej));
   // ==========================================================
   // Clock, pulse counters and hang limit.
   initial begin
      clk = 1'h0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (start === 1'h1) n_start <= n_start + 1;
      if (rej === 1'h1) n_rej <= n_rej + 1;
      if (cyc == 40000) begin
         miscompares++;
         close_out();
      end
   end
   // ==========================================================
   // Tasks.
   task automatic close_out();
      if (miscompares == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(string nm, logic [23:0] e, logic [23:0] g);
      checks++;
      if (g !== e) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic cmd(logic [39:0] d, int n, int es, int er);
      int s0, r0;
      s0 = n_start;
      r0 = n_rej;
      i_fwg_spi_host.frame(d, n);
      repeat (12) @(posedge clk);
      #1;
      chk("op_start", es, n_start - s0);
      if (er >= 0) chk("cmd_reject", er, n_rej - r0);
   endtask
   task automatic wait_done(int lo, int hi);
      int k;
      k = 0;
      while (done !== 1'h1 && k <= hi) begin
         @(posedge clk);
         #1;
         k++;
      end
      chk("duration", 1, k >= lo && k <= hi);
      @(posedge clk);
      #1;
      chk("busy_latch", 0, {busy, latch});
   endtask
   // ==========================================================
   // Scenarios.
   initial begin
      reset <= 1'h1;
      wp_n <= 1'h1;
      repeat (2) @(posedge clk);
      reset <= 1'h0;
      repeat (fwg_pkg::POWERUP_CYC + 20) @(posedge clk);
      #1;
      chk("status", 0, {busy, latch, susp, dpd, pb, compl, spb});
      cmd({8'h02, 32'h0}, 40, 0, 1);
      cmd({8'h06, 32'h0}, 8, 0, 0);
      cmd({8'h02, 24'h000100, 8'hA5}, 39, 0, -1);
      chk("latch", 1, latch);
      cmd({8'h02, 24'h000100, 8'hA5}, 40, 1, 0);
      chk("op", 24'h000100, {kind, addr});
      wait_done(PC - 9, PC - 2);
      foreach (PT[i]) begin
         p = PT[i];
         cmd({8'h06, 32'h0}, 8, 0, 0);
         cmd({8'h01, p[40:25], 16'h0}, 24, 0, 0);
         chk("protect", {p[39:35], p[31], p[25], p[40]},
            {pb, compl, spb});
         cmd({8'h06, 32'h0}, 8, 0, 0);
         cmd({8'h20, p[24:1], 8'h0}, 32, p[0], !p[0]);
         if (p[0]) wait_done(0, EC);
      end
      cmd({8'h06, 32'h0}, 8, 0, 0);
      cmd({8'h60, 32'h0}, 8, 0, 1);
      @(posedge clk);
      wp_n <= 1'h0;
      cmd({8'h01, 32'h0}, 24, 0, 1);
      chk("protect", 24'h01, {pb, compl});
      @(posedge clk);
      wp_n <= 1'h1;
      cmd({8'h01, 32'h0}, 24, 0, 0);
      for (int i = 0; i < 4; i++) begin
         cmd({8'h06, 32'h0}, 8, 0, 0);
         cmd({EOPC[i], 24'h010000, 8'h0}, 32, 1, 0);
         chk("op", {3'(i + 1), 21'h010000}, {kind, addr});
         wait_done(EC - 9, EC - 2);
      end
      cmd({8'hB9, 32'h0}, 8, 0, 0);
      cmd({8'h06, 32'h0}, 8, 0, 0);
      chk("pd_latch", 24'h2, {dpd, latch});
      cmd({8'hAB, 32'h0}, 8, 0, 0);
      cmd({8'h06, 32'h0}, 8, 0, 0);
      cmd({8'h20, 32'h0}, 32, 1, 0);
      cmd({8'h75, 32'h0}, 8, 0, 0);
      repeat (fwg_pkg::SUSPEND_LAT_CYC) @(posedge clk);
      #1;
      chk("suspend", 24'h3, {susp, busy});
      cmd({8'h7A, 32'h0}, 8, 0, 0);
      chk("resume", 24'h1, {susp, busy});
      wait_done(0, EC);
      close_out();
   end
endmodule
